// >>> rtl/sasq_pkg.sv
// package: constants and state codes of the serial adc port sequencer
package sasq_pkg;

    // ==========================================================
    // result and sequence figures
    localparam int         RES_W         = 12;
    localparam logic [3:0] MSB_IDX       = 4'hb;
    localparam logic [3:0] LSB_FIRST_IDX = 4'h1;
    localparam logic [3:0] LSB_LAST_IDX  = 4'hb;
    localparam logic [3:0] LSB_IDX       = 4'h0;
    localparam logic [2:0] LEAD_ONE_CH   = 3'h2;
    localparam logic [2:0] LEAD_TWO_CH   = 3'h4;
    localparam logic [1:0] CFG_LAST      = 2'h3;
    localparam logic [1:0] CFG_SAMPLE_AT = 2'h2;
    localparam logic [2:0] FALL_NONE     = 3'h0;
    localparam logic [2:0] FALL_ONE      = 3'h1;
    localparam logic [1:0] CFG_ZERO      = 2'h0;
    localparam logic [1:0] CFG_ONE       = 2'h1;

    // ==========================================================
    // configuration word layout, first received bit highest
    localparam int         CFG_W         = 3;
    localparam int         CFG_SGL_POS   = 2;
    localparam int         CFG_ODD_POS   = 1;
    localparam int         CFG_ORDER_POS = 0;
    localparam logic [2:0] CFG_RESET     = 3'h0;

    // ==========================================================
    // sequencer states
    typedef enum logic [6:0] {
        SASQ_IDLE  = 7'h01,
        SASQ_WAIT  = 7'h02,
        SASQ_LEAD  = 7'h04,
        SASQ_NULLB = 7'h08,
        SASQ_MSB   = 7'h10,
        SASQ_LSB   = 7'h20,
        SASQ_ZERO  = 7'h40
    } sasq_state_e;

endpackage

// >>> rtl/sasq_conv_if.sv
// interface: sequencer to successive approximation engine
`timescale 1ns/100ps
interface sasq_conv_if;
    logic                     clear;
    logic                     step;
    logic                     comp_high;
    logic [sasq_pkg::RES_W-1:0] trial;
    logic [sasq_pkg::RES_W-1:0] result;
    logic                     done;

    modport seq (output clear, output step, output comp_high,
                 input trial, input result, input done);
    modport sar (input clear, input step, input comp_high,
                 output trial, output result, output done);
endinterface

// >>> rtl/sasq_sar.sv
// module: successive approximation register engine
`timescale 1ns/100ps
module sasq_sar (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // sequencer side
    sasq_conv_if.sar  cv
);
    logic [3:0]                 idx_r;
    logic [sasq_pkg::RES_W-1:0] result_r;
    logic                       done_r;
    logic [sasq_pkg::RES_W-1:0] idx_hot;
    wire                        take = cv.step & ~done_r & ~cv.clear;

    // ==========================================================
    // one bit resolved per step, msb down to lsb
    assign idx_hot   = {{(sasq_pkg::RES_W-1){1'b0}}, 1'b1} << idx_r;
    assign cv.trial  = result_r | (done_r ? '0 : idx_hot);
    assign cv.result = result_r;
    assign cv.done   = done_r;

    generate
        for (genvar b = 0; b < sasq_pkg::RES_W; b++)
        begin : g_bit
            always_ff @(posedge clk)
            begin
                if (!rstn || cv.clear)
                    result_r[b] <= 1'b0;
                else if (take && idx_r == 4'(b))
                    result_r[b] <= cv.comp_high;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!rstn || cv.clear)
        begin
            idx_r  <= sasq_pkg::MSB_IDX;
            done_r <= 1'b0;
        end
        else if (take)
        begin
            idx_r  <= idx_r - 4'h1;
            done_r <= (idx_r == sasq_pkg::LSB_IDX);
        end
    end

    AST_SAR_DONE: assert property (@(posedge clk) disable iff (!rstn)
        take && idx_r == sasq_pkg::LSB_IDX |=> done_r && $stable(result_r[11:1]))
        else $error("engine did not finish after twelfth step");

endmodule // sasq_sar

// >>> rtl/sasq_top.sv
// module: serial port and conversion sequencer of a 12-bit sampling adc
// Operation
// - chip select low enables the part; high disables and powers it down.
// - output changes on falling shift clock, input sampled on rising edge.
// - shift clock paces both the transfer and the conversion steps.
// - output-only variant starts at select fall; output enabled at second pulse.
// - one null bit precedes the first result bit.
// - result is twelve bits from successive approximation.
// - select high returns the port to idle; host raises it each exchange.
// - two-channel variant takes configuration first, then returns result.
// - leading zeros on data input ignored; first one is the start bit.
// - three configuration bits follow start; they configure and start conversion.
// - data input ignored after configuration until select cycles.
// - output-only variant sends msb first, then the same result lsb first.
// - after the transfer, zeros are driven while select stays low.
// - bias and comparator power down when conversion ends.
// - input sampled for one and a half clocks, conversion twelve clocks.
// - first config bit picks single or pair, second picks channel or sign.
// - order bit one gives msb then zeros; zero adds lsb-first copy.
// - two-channel output driven low on fourth falling edge after start.
`timescale 1ns/100ps
module sasq_top (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // variant strap
    input  wire logic                       two_channel,
    // serial pins
    input  wire logic                       select_shutdown_n,
    input  wire logic                       shift_clk,
    input  wire logic                       data_in,
    output logic                            data_out,
    output logic                            data_out_oe,
    // analog side
    input  wire logic                       comparator_high,
    output logic [sasq_pkg::RES_W-1:0]      dac_trial,
    output logic                            sample_hold,
    output logic                            converter_powered,
    output logic                            single_or_pair_select,
    output logic                            odd_or_sign_select,
    output logic                            bit_order_select
);
    sasq_conv_if cv ();

    sasq_sar u_sar (
        .clk  (clk),
        .rstn (rstn),
        .cv   (cv)
    );

    sasq_pkg::sasq_state_e state_r;
    sasq_pkg::sasq_state_e state_nxt;
    logic                  clk_q_r;
    logic [2:0]            fall_cnt_r;
    logic [2:0]            fall_cnt_nxt;
    logic [1:0]            cfg_cnt_r;
    logic [1:0]            cfg_cnt_nxt;
    logic [sasq_pkg::CFG_W-1:0] cfg_r;
    logic [sasq_pkg::CFG_W-1:0] cfg_nxt;
    logic [3:0]            bit_idx_r;
    logic [3:0]            bit_idx_nxt;
    logic                  dout_r;
    logic                  dout_nxt;
    logic                  oe_r;
    logic                  oe_nxt;
    logic                  sample_r;
    logic                  sample_nxt;
    logic                  step;

    // ==========================================================
    // edge and phase decode
    wire       rise      = shift_clk & ~clk_q_r;
    wire       fall      = ~shift_clk & clk_q_r;
    wire       deselect  = select_shutdown_n;
    wire [2:0] lead_tgt  = two_channel ? sasq_pkg::LEAD_TWO_CH
                                       : sasq_pkg::LEAD_ONE_CH;
    wire [2:0] fall_inc  = fall_cnt_r + sasq_pkg::FALL_ONE;
    wire       lead_hit  = fall && fall_inc == lead_tgt;
    wire       cfg_take  = rise && two_channel && cfg_cnt_r != sasq_pkg::CFG_LAST;
    wire [1:0] cfg_inc   = cfg_cnt_r + sasq_pkg::CFG_ONE;
    wire       samp_go1  = rise && !two_channel && fall_cnt_r == sasq_pkg::FALL_NONE;
    wire       samp_go2  = cfg_take && cfg_inc == sasq_pkg::CFG_SAMPLE_AT;
    wire       last_msb  = bit_idx_r == sasq_pkg::LSB_IDX;
    wire       want_lsb  = !two_channel || !cfg_r[sasq_pkg::CFG_ORDER_POS];
    wire       last_lsb  = bit_idx_r == sasq_pkg::LSB_LAST_IDX;
    wire [3:0] lsb_next  = bit_idx_r + 4'h1;
    wire       in_conv   = state_r == sasq_pkg::SASQ_LEAD
                        || state_r == sasq_pkg::SASQ_NULLB
                        || state_r == sasq_pkg::SASQ_MSB;

    // ==========================================================
    // engine hookup
    assign cv.clear     = state_r == sasq_pkg::SASQ_IDLE
                       || state_r == sasq_pkg::SASQ_WAIT
                       || state_r == sasq_pkg::SASQ_LEAD;
    assign cv.step      = step;
    assign cv.comp_high = comparator_high;

    // ==========================================================
    // outputs
    assign data_out          = dout_r;
    assign data_out_oe       = oe_r;
    assign dac_trial         = cv.trial;
    assign sample_hold       = sample_r;
    assign converter_powered = !deselect && in_conv && !cv.done;
    assign single_or_pair_select = cfg_r[sasq_pkg::CFG_SGL_POS];
    assign odd_or_sign_select    = cfg_r[sasq_pkg::CFG_ODD_POS];
    assign bit_order_select      = cfg_r[sasq_pkg::CFG_ORDER_POS];

    // ==========================================================
    // sequence control
    always_comb
    begin
        state_nxt    = state_r;
        fall_cnt_nxt = fall_cnt_r;
        cfg_cnt_nxt  = cfg_cnt_r;
        cfg_nxt      = cfg_r;
        bit_idx_nxt  = bit_idx_r;
        dout_nxt     = dout_r;
        oe_nxt       = oe_r;
        sample_nxt   = sample_r;
        step         = 1'b0;
        case (state_r)
            sasq_pkg::SASQ_IDLE:
            begin
                fall_cnt_nxt = sasq_pkg::FALL_NONE;
                cfg_cnt_nxt  = sasq_pkg::CFG_ZERO;
                cfg_nxt      = sasq_pkg::CFG_RESET;
                if (two_channel)
                    state_nxt = sasq_pkg::SASQ_WAIT;
                else
                    state_nxt = sasq_pkg::SASQ_LEAD;
            end
            sasq_pkg::SASQ_WAIT:
            begin
                if (rise && data_in)
                    state_nxt = sasq_pkg::SASQ_LEAD;
            end
            sasq_pkg::SASQ_LEAD:
            begin
                if (cfg_take)
                begin
                    cfg_nxt     = {cfg_r[sasq_pkg::CFG_W-2:0], data_in};
                    cfg_cnt_nxt = cfg_inc;
                end
                if (samp_go1 || samp_go2)
                    sample_nxt = 1'b1;
                if (fall)
                    fall_cnt_nxt = fall_inc;
                if (lead_hit)
                begin
                    state_nxt  = sasq_pkg::SASQ_NULLB;
                    oe_nxt     = 1'b1;
                    dout_nxt   = 1'b0;
                    sample_nxt = 1'b0;
                end
            end
            sasq_pkg::SASQ_NULLB:
            begin
                if (fall)
                begin
                    state_nxt   = sasq_pkg::SASQ_MSB;
                    step        = 1'b1;
                    bit_idx_nxt = sasq_pkg::MSB_IDX;
                    dout_nxt    = comparator_high;
                end
            end
            sasq_pkg::SASQ_MSB:
            begin
                if (fall && last_msb)
                begin
                    if (want_lsb)
                    begin
                        state_nxt   = sasq_pkg::SASQ_LSB;
                        bit_idx_nxt = sasq_pkg::LSB_FIRST_IDX;
                        dout_nxt    = cv.result[sasq_pkg::LSB_FIRST_IDX];
                    end
                    else
                    begin
                        state_nxt = sasq_pkg::SASQ_ZERO;
                        dout_nxt  = 1'b0;
                    end
                end
                else if (fall)
                begin
                    step        = 1'b1;
                    bit_idx_nxt = bit_idx_r - 4'h1;
                    dout_nxt    = comparator_high;
                end
            end
            sasq_pkg::SASQ_LSB:
            begin
                if (fall && last_lsb)
                begin
                    state_nxt = sasq_pkg::SASQ_ZERO;
                    dout_nxt  = 1'b0;
                end
                else if (fall)
                begin
                    bit_idx_nxt = lsb_next;
                    dout_nxt    = cv.result[lsb_next];
                end
            end
            sasq_pkg::SASQ_ZERO:
            begin
                dout_nxt = 1'b0;
            end
            default:
            begin
                state_nxt = sasq_pkg::SASQ_IDLE;
            end
        endcase
        if (deselect)
        begin
            state_nxt  = sasq_pkg::SASQ_IDLE;
            oe_nxt     = 1'b0;
            dout_nxt   = 1'b0;
            sample_nxt = 1'b0;
            step       = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_r    <= sasq_pkg::SASQ_IDLE;
            clk_q_r    <= 1'b0;
            fall_cnt_r <= sasq_pkg::FALL_NONE;
            cfg_cnt_r  <= sasq_pkg::CFG_ZERO;
            cfg_r      <= sasq_pkg::CFG_RESET;
            bit_idx_r  <= sasq_pkg::MSB_IDX;
            dout_r     <= 1'b0;
            oe_r       <= 1'b0;
            sample_r   <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            clk_q_r    <= shift_clk;
            fall_cnt_r <= fall_cnt_nxt;
            cfg_cnt_r  <= cfg_cnt_nxt;
            cfg_r      <= cfg_nxt;
            bit_idx_r  <= bit_idx_nxt;
            dout_r     <= dout_nxt;
            oe_r       <= oe_nxt;
            sample_r   <= sample_nxt;
        end
    end

    // ==========================================================
    // checks
    AST_DESELECT_IDLE: assert property (@(posedge clk) disable iff (!rstn)
        deselect |=> state_r == sasq_pkg::SASQ_IDLE && !oe_r && !converter_powered)
        else $error("select high did not idle the port");

    AST_OUT_ON_FALL: assert property (@(posedge clk) disable iff (!rstn)
        $changed(dout_r) |-> $past(fall) || $past(deselect))
        else $error("data output changed away from a falling edge");

    AST_ONE_CH_START: assert property (@(posedge clk) disable iff (!rstn)
        state_r == sasq_pkg::SASQ_IDLE && !deselect && !two_channel
        |=> state_r == sasq_pkg::SASQ_LEAD)
        else $error("output-only variant did not start on select fall");

    AST_NULL_BIT: assert property (@(posedge clk) disable iff (!rstn)
        state_r == sasq_pkg::SASQ_NULLB |-> oe_r && !dout_r)
        else $error("null bit not driven low");

    AST_START_BIT: assert property (@(posedge clk) disable iff (!rstn)
        state_r == sasq_pkg::SASQ_WAIT && !deselect && rise && !data_in
        |=> state_r == sasq_pkg::SASQ_WAIT)
        else $error("leading zero taken as start");

    AST_CFG_FROZEN: assert property (@(posedge clk) disable iff (!rstn)
        !deselect && state_r inside {sasq_pkg::SASQ_NULLB, sasq_pkg::SASQ_MSB,
            sasq_pkg::SASQ_LSB, sasq_pkg::SASQ_ZERO} |=> $stable(cfg_r))
        else $error("configuration changed after capture");

    AST_ZERO_TAIL: assert property (@(posedge clk) disable iff (!rstn)
        state_r == sasq_pkg::SASQ_ZERO && !deselect |=> !dout_r && oe_r)
        else $error("tail not zero");

    AST_ORDER_SKIP: assert property (@(posedge clk) disable iff (!rstn)
        state_r == sasq_pkg::SASQ_MSB && fall && last_msb && !deselect && !want_lsb
        |=> state_r == sasq_pkg::SASQ_ZERO)
        else $error("order bit one still sent lsb copy");

    AST_ENABLE_POINT: assert property (@(posedge clk) disable iff (!rstn)
        $rose(oe_r) |-> $past(fall) && $past(fall_inc) == $past(lead_tgt))
        else $error("output enabled at wrong edge");

    AST_STEP_ON_FALL: assert property (@(posedge clk) disable iff (!rstn)
        step |-> fall && !deselect)
        else $error("conversion stepped away from a falling edge");

    AST_LSB_COPY: assert property (@(posedge clk) disable iff (!rstn)
        state_r == sasq_pkg::SASQ_LSB |-> oe_r && dout_r == cv.result[bit_idx_r])
        else $error("lsb copy does not match the held result");

    AST_POWER_DOWN: assert property (@(posedge clk) disable iff (!rstn)
        state_r == sasq_pkg::SASQ_MSB && last_msb && !deselect |-> cv.done && !converter_powered)
        else $error("converter not powered down at end of conversion");

    AST_SAMPLE_SPAN: assert property (@(posedge clk) disable iff (!rstn)
        sample_r |-> state_r == sasq_pkg::SASQ_LEAD && !oe_r)
        else $error("sampling outside the lead phase");

endmodule // sasq_top

// >>> bench/sasq_host_model.sv
// partner model: serial host master driving select, shift clock and data input
`timescale 1ns/100ps
module sasq_host_model (
    // clock
    input  wire logic clk,
    // serial pins
    output logic      select_shutdown_n,
    output logic      shift_clk,
    output logic      data_in,
    input  wire logic data_out,
    input  wire logic data_out_oe,
    // observed status
    input  wire logic sample_hold,
    input  wire logic converter_powered
);
    // ==========================================================
    // line as the host sees it: an undriven pin reads inverted
    wire        data_line = data_out_oe ? data_out : ~data_out;

    // per rise record: hold, powered, enable, data
    logic [3:0] rec [0:63];

    initial
    begin
        select_shutdown_n = 1'b1;
        shift_clk         = 1'b0;
        data_in           = 1'b0;
    end

    // ==========================================================
    // input bit for rise j: zeros, start, config, then toggling
    function automatic logic in_bit(input logic two_ch, input int z,
                                    input logic [2:0] cfg, input int j, input logic last);
        if (!two_ch || j > z + 3)
            return ~last;
        if (j < z)
            return 1'b0;
        if (j == z)
            return 1'b1;
        return cfg[z + 3 - j];
    endfunction

    task automatic half();
        repeat (4) @(posedge clk);
        #2;
    endtask

    // ==========================================================
    // exchange of n shift clocks, select left low
    task automatic frame(input logic two_ch, input int z, input logic [2:0] cfg, input int n);
        @(posedge clk);
        #2;
        select_shutdown_n = 1'b0;
        data_in           = in_bit(two_ch, z, cfg, 0, data_in);
        half();
        for (int i = 0; i < n; i++)
        begin
            rec[i]    = {sample_hold, converter_powered, data_out_oe, data_line};
            shift_clk = 1'b1;
            half();
            shift_clk = 1'b0;
            data_in   = in_bit(two_ch, z, cfg, i + 1, data_in);
            half();
        end
    endtask

    // end of exchange, shift clock stands still
    task automatic release_bus();
        select_shutdown_n = 1'b1;
        data_in           = ~data_in;
    endtask
endmodule // sasq_host_model

// >>> bench/tb.sv
// testbench: serial port and conversion sequencer of the 12-bit adc
`timescale 1ns/100ps
module tb;
    // ==========================================================
    // signals
    logic        clk;
    logic        rstn;
    logic        two_channel;
    logic        select_shutdown_n;
    logic        shift_clk;
    logic        data_in;
    logic        data_out;
    logic        data_out_oe;
    logic        comparator_high;
    logic [11:0] dac_trial;
    logic        sample_hold;
    logic        converter_powered;
    logic        single_or_pair_select;
    logic        odd_or_sign_select;
    logic        bit_order_select;
    logic [11:0] analog_level;
    int          n_errors;
    int          total_checks;
    int          n_test;

    // comparator: input at or above trial code
    assign comparator_high = (analog_level >= dac_trial);

    always #10 clk = ~clk;

    sasq_top i_sasq_top (
        .clk                   (clk),
        .rstn                  (rstn),
        .two_channel           (two_channel),
        .select_shutdown_n     (select_shutdown_n),
        .shift_clk             (shift_clk),
        .data_in               (data_in),
        .data_out              (data_out),
        .data_out_oe           (data_out_oe),
        .comparator_high       (comparator_high),
        .dac_trial             (dac_trial),
        .sample_hold           (sample_hold),
        .converter_powered     (converter_powered),
        .single_or_pair_select (single_or_pair_select),
        .odd_or_sign_select    (odd_or_sign_select),
        .bit_order_select      (bit_order_select)
    );

    sasq_host_model i_sasq_host_model (
        .clk               (clk),
        .select_shutdown_n (select_shutdown_n),
        .shift_clk         (shift_clk),
        .data_in           (data_in),
        .data_out          (data_out),
        .data_out_oe       (data_out_oe),
        .sample_hold       (sample_hold),
        .converter_powered (converter_powered)
    );

    // ==========================================================
    // compare and verdict
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic idle_check();
        repeat (3) @(posedge clk);
        #2;
        check("enable idle", 12'(data_out_oe), 12'h000);
        check("powered idle", 12'(converter_powered), 12'h000);
    endtask

    // ==========================================================
    // one exchange of n rises, then every recorded rise compared
    task automatic run(input logic two_ch, input int z, input logic [2:0] cfg,
                       input logic [11:0] v, input int n);
        int          b;
        logic [3:0]  r;
        logic [11:0] e;
        @(posedge clk);
        #2;
        two_channel  = two_ch;
        analog_level = v;
        i_sasq_host_model.frame(two_ch, z, cfg, n);
        b = two_ch ? z + 4 : 2;
        for (int i = 0; i < n; i++)
        begin
            r = i_sasq_host_model.rec[i];
            e = 12'h000;
            if (i > b && i <= b + 12)
                e = 12'(v[b + 12 - i]);
            else if (i > b + 12 && i <= b + 23 && !(two_ch && cfg[0]))
                e = 12'(v[i - b - 12]);
            check("enable", 12'(r[1]), 12'(i >= b));
            if (i >= b)
                check("data", 12'(r[0]), e);
        end
        if (n > b + 1)
        begin
            check("hold", 12'(i_sasq_host_model.rec[b - 1][3]), 12'h001);
            check("hold end", 12'(i_sasq_host_model.rec[b + 1][3]), 12'h000);
            check("powered", 12'(i_sasq_host_model.rec[b + 1][2]), 12'h001);
        end
        if (n > b + 13)
        begin
            check("powered end", 12'(i_sasq_host_model.rec[b + 13][2]), 12'h000);
            check("result", dac_trial, v);
        end
        check("config", 12'({single_or_pair_select, odd_or_sign_select, bit_order_select}),
              12'(two_ch ? cfg : 3'h0));
        i_sasq_host_model.release_bus();
        idle_check();
        n_test++;
        $display("test %0d done, checks so far %0d", n_test, total_checks);
    endtask

    // ==========================================================
    // sequence of tests
    initial
    begin
        clk          = 1'b0;
        rstn         = 1'b0;
        two_channel  = 1'b0;
        analog_level = 12'h000;
        n_errors     = 0;
        total_checks = 0;
        n_test       = 0;
        repeat (12) @(posedge clk);
        #2;
        rstn = 1'b1;
        idle_check();
        run(1'b0, 0, 3'h0, 12'ha5c, 30);
        run(1'b0, 0, 3'h0, 12'h3c1, 15);
        run(1'b0, 0, 3'h0, 12'h0ff, 6);
        for (int k = 0; k < 8; k++)
            run(1'b1, k, 3'(k), 12'h5a3 ^ 12'(k * 291), 36);
        run(1'b1, 1, 3'h6, 12'hfff, 8);
        run(1'b1, 2, 3'h2, 12'h001, 36);
        run(1'b0, 0, 3'h0, 12'h000, 30);
        stop_test();
    end

    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end
endmodule // tb
